// >>> fbmac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fbmac_ctrl
    import fbmac_pkg::*;
(
    input wire logic i_sys_clk, // System clock, 10 MHz.
    input wire logic i_reset, // Synchronous active-high reset.
    input wire logic i_clk_en, // Freezes all state while low.
    input wire logic i_top_boot, // Layout of the attached variant, held static.
    input wire logic i_has_rdy_pin, // High when the variant has a ready-busy pin.
    input wire logic i_req_valid, // Request strobe.
    input wire logic i_req_write, // High for a write cycle.
    input wire logic i_req_flash_reset, // High for a hardware reset pulse.
    input wire logic [ADDR_W-1:0] i_req_addr, // Request word address.
    input wire logic [DATA_W-1:0] i_req_wdata, // Write data.
    input wire logic [DATA_W-1:0] i_dq_in, // Data pins as seen on the bus.
    input wire logic i_ready_busy_n, // Ready-busy pin from the device.
    output logic o_req_ready, // High when a request may be given.
    output logic o_rsp_valid, // One-cycle pulse with read data.
    output logic [DATA_W-1:0] o_rsp_rdata, // Read data.
    output logic [3:0] o_rsp_sector, // Sector number of the request address.
    output logic o_autoselect, // High while the device is in command autoselect.
    output logic o_busy, // Registered busy indication.
    output logic o_ce_n, // Chip enable to the device, active low.
    output logic o_oe_n, // Output enable, active low.
    output logic o_we_n, // Write enable, active low.
    output logic o_reset_n, // Hardware reset, active low.
    output logic [ADDR_W-1:0] o_addr, // Address pins.
    output logic [DATA_W-1:0] o_dq_out, // Data pin drive value.
    output logic o_dq_oe // High while the controller drives the data pins.
);

    // ****************************************************************
    // Registers.
    // ****************************************************************
    fbmac_state_t state_reg, state_next; // Sequencer state.
    logic [CNT_W-1:0] cnt_reg; // Shared delay counter.
    logic [1:0] unlock_reg; // Unlock sequence progress.

    // ****************************************************************
    // Sector decode, one comparison per sector in a generate loop.
    // ****************************************************************
    wire [5:0] hi = i_req_addr[17:12]; // High address bits that pick a sector.
    logic [SECTORS-1:0] top_hit; // Top-layout sector matches.
    logic [SECTORS-1:0] bot_hit; // Bottom-layout sector matches.
    genvar g;
    generate
        for (g = 0; g < SECTORS; g++) begin : g_sect
            if (g < 7) begin : g_big
                // Seven large sectors on bits 17-15; bottom layout starts at 001.
                assign top_hit[g] = (hi[5:3] == 3'(g));
                assign bot_hit[g + 4] = (hi[5:3] == 3'(g + 1));
            end else begin : g_small
                // Top boot sectors sit at the top, mirrored near zero for bottom.
                assign top_hit[g] = (g == 7) ? (hi[5:2] == 4'hE) :
                    (g == 8) ? (hi == 6'h3C) : (g == 9) ? (hi == 6'h3D) :
                    (hi[5:1] == 5'h1F);
                assign bot_hit[g - 7] = (g == 7) ? (hi[5:1] == 5'h00) :
                    (g == 8) ? (hi == 6'h02) : (g == 9) ? (hi == 6'h03) :
                    (hi[5:2] == 4'h1);
            end
        end
    endgenerate

    // Priority encode the fixed layout's match vector.
    logic [3:0] sect_num;
    always_comb begin
        sect_num = SECT_BAD;
        for (int k = 0; k < SECTORS; k++) begin
            if (i_top_boot ? top_hit[k] : bot_hit[k]) begin
                sect_num = 4'(k);
            end
        end
    end

    // ****************************************************************
    // Command tracking decodes.
    // ****************************************************************
    wire issue = i_clk_en && o_req_ready && i_req_valid; // Request accepted.
    wire is_u1 = i_req_addr[10:0] == UNLOCK1_ADDR[10:0] && i_req_wdata[7:0] == UNLOCK1_DATA[7:0];
    wire is_u2 = i_req_addr[10:0] == UNLOCK2_ADDR[10:0] && i_req_wdata[7:0] == UNLOCK2_DATA[7:0];
    wire is_as = unlock_reg == 2'h2 && i_req_addr[10:0] == UNLOCK1_ADDR[10:0]
        && i_req_wdata[7:0] == AUTOSEL_CMD[7:0];
    wire is_rst_cmd = i_req_wdata[7:0] == RESET_CMD[7:0];
    wire [1:0] next_unlock = is_u1 ? 2'h1 : (unlock_reg == 2'h1 && is_u2) ? 2'h2 : 2'h0;
    // Busy from the pin where present; otherwise reported idle, so the reset wait
    // then rests on the delay counter alone.
    wire dev_busy = i_has_rdy_pin ? !i_ready_busy_n : 1'b0;

    // ****************************************************************
    // Sequencer next state.
    // ****************************************************************
    wire cnt_done = cnt_reg == '0;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            FBMAC_IDLE: begin
                if (issue) begin
                    state_next = i_req_flash_reset ? FBMAC_RST_LOW :
                        i_req_write ? FBMAC_WRITE : FBMAC_READ;
                end
            end
            FBMAC_RST_LOW: if (cnt_done) state_next = FBMAC_RST_WAIT;
            FBMAC_RST_WAIT: if (cnt_done && !dev_busy) state_next = FBMAC_IDLE;
            FBMAC_READ: if (cnt_done) state_next = FBMAC_GAP;
            FBMAC_WRITE: if (cnt_done) state_next = FBMAC_GAP;
            FBMAC_GAP: state_next = FBMAC_IDLE;
        endcase
    end

    // Counter load value on each state entry.
    wire [CNT_W-1:0] cnt_load =
        (state_next == FBMAC_RST_LOW) ? CNT_W'(RP_CYC - 1) :
        (state_next == FBMAC_RST_WAIT) ? CNT_W'(RH_CYC + READY_CYC / 8) :
        (state_next == FBMAC_READ) ? CNT_W'(ACC_CYC) :
        CNT_W'(WP_CYC - 1);
    wire entering = state_next != state_reg;

    // ****************************************************************
    // State, counter and command tracking registers.
    // ****************************************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_reg <= FBMAC_IDLE;
            cnt_reg <= '0;
            unlock_reg <= 2'h0;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            cnt_reg <= entering ? cnt_load : (cnt_done ? cnt_reg : cnt_reg - 1'b1);
            if (issue && i_req_flash_reset) begin
                unlock_reg <= 2'h0;
            end else if (issue && i_req_write) begin
                unlock_reg <= next_unlock;
            end
        end
    end

    // ****************************************************************
    // Pin and answer registers.
    // ****************************************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_reset_n <= 1'b1;
            o_addr <= '0;
            o_dq_out <= '0;
            o_dq_oe <= 1'b0;
            o_req_ready <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= '0;
            o_rsp_sector <= SECT_BAD;
            o_autoselect <= 1'b0;
            o_busy <= 1'b0;
        end else if (i_clk_en) begin
            // Address held stable after a cycle so the device may sleep with data kept.
            if (issue) begin
                o_addr <= i_req_addr;
                o_dq_out <= i_req_wdata;
                o_rsp_sector <= sect_num;
            end
            o_ce_n <= !(state_next == FBMAC_READ || state_next == FBMAC_WRITE);
            o_oe_n <= state_next != FBMAC_READ;
            o_we_n <= state_next != FBMAC_WRITE;
            o_dq_oe <= state_next == FBMAC_WRITE;
            o_reset_n <= state_next != FBMAC_RST_LOW;
            o_req_ready <= state_next == FBMAC_IDLE;
            o_busy <= dev_busy;
            // Data sampled only after the full access time elapses.
            o_rsp_valid <= state_reg == FBMAC_READ && cnt_done;
            if (state_reg == FBMAC_READ && cnt_done) begin
                o_rsp_rdata <= i_dq_in;
            end
            if (issue && i_req_flash_reset) begin
                o_autoselect <= 1'b0;
            end else if (issue && i_req_write && is_as) begin
                o_autoselect <= 1'b1;
            end else if (issue && i_req_write && is_rst_cmd) begin
                o_autoselect <= 1'b0;
            end
        end
    end

    // Aborted operations are left for the requester to issue again.
    // Codes at offsets AS_MANUF, AS_DEVICE, AS_CONT and AS_PROTECT come back as plain reads.

endmodule : fbmac_ctrl
`default_nettype wire

// >>> fbmac_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the pin protocol of the controller.
module fbmac_ctrl_checker
    import fbmac_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic i_req_flash_reset,
    input wire logic o_req_ready,
    input wire logic o_rsp_valid,
    input wire logic o_ce_n,
    input wire logic o_oe_n,
    input wire logic o_we_n,
    input wire logic o_reset_n,
    input wire logic o_dq_oe
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // A read request is taken on this edge.
    wire logic take_rd = i_clk_en && o_req_ready && i_req_valid && !i_req_write
        && !i_req_flash_reset;
    a_read_answer_time: assert property (take_rd |-> ##3 o_rsp_valid)
        else $error("read answer not on time");
    a_sample_after_access: assert property (
        o_rsp_valid |-> !$past(o_oe_n) && !$past(o_oe_n, 2))
        else $error("read data taken before access time");
    a_rsp_single_pulse: assert property (o_rsp_valid |=> !o_rsp_valid)
        else $error("response pulse too long");
    a_idle_standby: assert property (o_req_ready |-> o_ce_n)
        else $error("device selected while idle");
    a_read_no_drive: assert property (!o_oe_n |-> !o_dq_oe && o_we_n)
        else $error("bus fight during read");
    a_write_strobe_once: assert property (
        $fell(o_we_n) |-> !o_ce_n && o_oe_n && o_dq_oe ##1 o_we_n)
        else $error("bad write strobe");
    a_reset_pulse_width: assert property ($fell(o_reset_n) |-> !o_reset_n [*5])
        else $error("reset pulse too short");
    a_reset_bus_quiet: assert property (
        !o_reset_n |-> o_ce_n && o_oe_n && o_we_n && !o_dq_oe)
        else $error("access during reset");
    a_reset_to_read: assert property ($rose(o_reset_n) |-> o_ce_n ##1 o_ce_n)
        else $error("read too soon after reset");
endmodule : fbmac_ctrl_checker
bind fbmac_ctrl fbmac_ctrl_checker fbmac_ctrl_checker_inst (.i_sys_clk, .i_reset, .i_clk_en,
    .i_req_valid, .i_req_write, .i_req_flash_reset, .o_req_ready, .o_rsp_valid, .o_ce_n,
    .o_oe_n, .o_we_n, .o_reset_n, .o_dq_oe);
`default_nettype wire

// >>> fbmac_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module fbmac_ctrl_test;
    import fbmac_pkg::*;
    localparam logic [15:0] MID = 16'h005A, DTOP = 16'h2211, DBOT = 16'h2233, CID = 16'h006C;
    logic i_sys_clk = 0, i_reset = 1, i_top_boot = 1, i_has_rdy_pin = 1, start_op = 0;
    logic i_req_valid = 0, i_req_write = 0, i_req_flash_reset = 0;
    logic [17:0] i_req_addr = 0;
    logic [15:0] i_req_wdata = 0, dq_dev, o_rsp_rdata, o_dq_out;
    logic rbn, o_req_ready, o_rsp_valid, o_autoselect, o_busy, o_dq_oe;
    logic o_ce_n, o_oe_n, o_we_n, o_reset_n;
    // The data bus as both sides see it: the controller's drive wins while enabled.
    wire logic [15:0] bus = o_dq_oe ? o_dq_out : dq_dev;
    logic [3:0] o_rsp_sector;
    logic [17:0] o_addr;
    int mismatches = 0, checks = 0;
    logic [31:0] seed = 32'h65C84D10;
    logic [19:0] expq[$];
    logic [17:0] bnd[12] = '{18'h37FFF, 18'h38000, 18'h3BFFF, 18'h3C000, 18'h3D000, 18'h3E000,
        18'h00000, 18'h01FFF, 18'h02000, 18'h03000, 18'h04000, 18'h08000};
    fbmac_ctrl fbmac_ctrl_inst (.i_sys_clk, .i_reset, .i_clk_en(1'b1), .i_top_boot, .i_has_rdy_pin,
        .i_req_valid, .i_req_write, .i_req_flash_reset, .i_req_addr, .i_req_wdata, .i_dq_in(bus),
        .i_ready_busy_n(rbn), .o_req_ready, .o_rsp_valid, .o_rsp_rdata, .o_rsp_sector,
        .o_autoselect, .o_busy, .o_ce_n, .o_oe_n, .o_we_n, .o_reset_n, .o_addr,
        .o_dq_out, .o_dq_oe);
    fbmac_flash_model #(.MANUF_ID(MID), .DEV_TOP(DTOP), .DEV_BOT(DBOT), .CONT_ID(CID))
        fbmac_flash_model_inst (.i_sys_clk, .i_start_op(start_op), .i_top_boot, .i_ce_n(o_ce_n),
        .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_reset_n(o_reset_n), .i_addr(o_addr), .i_dq(bus),
        .o_dq(dq_dev), .o_ready_busy_n(rbn));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Sector number expected for an address in the current layout.
    function automatic logic [3:0] sect(input logic [17:0] x);
        if (i_top_boot) begin
            if (x[17:15] != 3'h7) return {1'b0, x[17:15]};
            return !x[14] ? 4'h7 : x[13] ? 4'hA : {3'h4, x[12]};
        end
        if (x[17:15] != 3'h0) return {1'b0, x[17:15]} + 4'h3;
        return x[14] ? 4'h3 : !x[13] ? 4'h0 : {2'h0, x[12], !x[12]};
    endfunction : sect
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // Waits under a bound until the controller is idle, so any answer has been compared.
    task automatic wait_ready;
        int n;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 3000) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n == 3000) begin
            mismatches++;
            wrap_up();
        end
    endtask : wait_ready
    // Waits for ready under a bound, then presents one request for one edge.
    task automatic req(input logic w, input logic r, input logic [17:0] x, input logic [15:0] d);
        wait_ready();
        {i_req_valid, i_req_write, i_req_flash_reset} = {1'b1, w, r};
        {i_req_addr, i_req_wdata} = {x, d};
        @(negedge i_sys_clk);
        i_req_valid = 0;
    endtask : req
    task automatic rd(input logic [17:0] x, input logic [15:0] d);
        expq.push_back({sect(x), d});
        req(0, 0, x, 16'h0000);
    endtask : rd
    initial forever #50 i_sys_clk = ~i_sys_clk;
    // Compares each read answer with the oldest expectation.
    always @(posedge i_sys_clk) if (o_rsp_valid === 1'b1) begin
        if (expq.size() == 0) check({o_rsp_sector, o_rsp_rdata}, 20'hFFFFF);
        else check({o_rsp_sector, o_rsp_rdata}, expq.pop_front());
    end
    initial begin
        for (int l = 1; l >= 0; l--) begin
            i_reset = 1;
            i_top_boot = l[0];
            repeat (4) @(negedge i_sys_clk);
            i_reset = 0;
            @(negedge i_sys_clk);
            foreach (bnd[i]) rd(bnd[i], bnd[i][15:0] ^ 16'h3C3C);
            for (int k = 0; k < 6; k++) begin
                seed = lfsr(seed);
                rd(seed[17:0], seed[15:0] ^ 16'h3C3C);
            end
            // Let the last read answer before the next reset cuts it off.
            wait_ready();
        end
        req(1, 0, UNLOCK1_ADDR, UNLOCK1_DATA);
        req(1, 0, UNLOCK2_ADDR, UNLOCK2_DATA);
        req(1, 0, UNLOCK1_ADDR, AUTOSEL_CMD);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            rd({1'b1, seed[16:2], k[1:0]}, k == 0 ? MID : k == 1 ? DBOT : k == 2 ? 16'h0001 : CID);
        end
        rd({1'b0, seed[16:2], AS_PROTECT}, 16'h0000);
        check(20'(o_autoselect), 20'h1);
        req(1, 0, seed[17:0], RESET_CMD);
        rd(seed[17:0], seed[15:0] ^ 16'h3C3C);
        check(20'(o_autoselect), 20'h0);
        // Hardware reset of an idle device, then an array read.
        req(0, 1, 18'h00000, 16'h0000);
        rd(18'h3FFFF, 16'hC3C3);
        // The operation must not start while a read is still on the bus.
        wait_ready();
        start_op = 1;
        @(negedge i_sys_clk);
        start_op = 0;
        rd(18'h01234, 16'h00C8);
        rd(18'h2ABCD, 16'h00C8);
        check(20'(o_busy), 20'h1);
        req(0, 1, 18'h00000, 16'h0000);
        rd(18'h01234, 16'h2E08);
        check(20'(o_busy), 20'h0);
        wait_ready();
        start_op = 1;
        i_has_rdy_pin = 0;
        repeat (3) @(negedge i_sys_clk);
        start_op = 0;
        check(20'(o_busy), 20'h0);
        i_has_rdy_pin = 1;
        repeat (5) @(negedge i_sys_clk);
        check(20'(o_busy), 20'h1);
        check(20'(expq.size()), 20'h0);
        wrap_up();
    end
endmodule : fbmac_ctrl_test
`default_nettype wire

// >>> fbmac_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural flash device; identity codes are arbitrary.
module fbmac_flash_model
    import fbmac_pkg::*;
#(
    parameter logic [15:0] MANUF_ID = 16'h005A,
    parameter logic [15:0] DEV_TOP = 16'h2211,
    parameter logic [15:0] DEV_BOT = 16'h2233,
    parameter logic [15:0] CONT_ID = 16'h006C
)
(
    input wire logic i_sys_clk,
    input wire logic i_start_op,
    input wire logic i_top_boot,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_reset_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0] o_dq,
    output logic o_ready_busy_n
);
    logic [1:0] unlock = 2'h0;
    logic asel = 1'b0;
    int op_cnt = 0;
    int rcv_cnt = 0;
    logic [15:0] val;
    logic [15:0] last = 16'h0000;
    // Answer at once for any address, so sleep never delays data.
    always_comb begin
        if (op_cnt != 0) val = 16'h00C8;
        else if (!asel) val = i_addr[15:0] ^ 16'h3C3C;
        else case (i_addr[1:0])
            2'h0: val = MANUF_ID;
            2'h1: val = i_top_boot ? DEV_TOP : DEV_BOT;
            2'h2: val = {8'h00, i_addr[17] ? PROT_YES : PROT_NO};
            default: val = CONT_ID;
        endcase
    end
    // A released bus shows the inverse of the last value driven.
    assign o_dq = (!i_ce_n && !i_oe_n && i_reset_n) ? val : ~last;
    assign o_ready_busy_n = (op_cnt == 0) && (rcv_cnt == 0);
    always @(posedge i_sys_clk) begin
        if (!i_ce_n && !i_oe_n && i_reset_n) last <= val;
        if (!i_reset_n) begin
            unlock <= 2'h0;
            asel <= 1'b0;
            if (op_cnt != 0) rcv_cnt <= 20;
            op_cnt <= 0;
        end else begin
            if (rcv_cnt != 0) rcv_cnt <= rcv_cnt - 1;
            if (i_start_op) op_cnt <= 300;
            else if (op_cnt != 0) op_cnt <= op_cnt - 1;
            if (!i_ce_n && !i_we_n) begin
                if (i_dq == RESET_CMD) asel <= 1'b0;
                if (unlock == 2'h2 && i_addr == UNLOCK1_ADDR && i_dq == AUTOSEL_CMD) begin
                    asel <= 1'b1;
                end
                if (i_addr == UNLOCK1_ADDR && i_dq == UNLOCK1_DATA) begin
                    unlock <= 2'h1;
                end else if (unlock == 2'h1 && i_addr == UNLOCK2_ADDR
                        && i_dq == UNLOCK2_DATA) begin
                    unlock <= 2'h2;
                end else begin
                    unlock <= 2'h0;
                end
            end
        end
    end
endmodule : fbmac_flash_model
`default_nettype wire

// >>> fbmac_pkg.sv
// Summary of operation
// - Reads during embedded operation return status
// - Wait chip-enable access time before sampling data
// - Reissue aborted operation after reset completes (the controller does not reissue; it leaves this to the requester)
// - Wait reset-high-to-read before first read
// - Address bits 1:0 select the identification code
// - Reset command leaves command autoselect mode
package fbmac_pkg;

    // ****************************************************************
    // Bus widths.
    // ****************************************************************
    localparam int ADDR_W = 18; // Word address width.
    localparam int DATA_W = 16; // Data bus width.

    // ****************************************************************
    // Timing, in nanoseconds and in 10 MHz clock cycles.
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 100; // System clock period.
    localparam int ADDRESS_ACCESS_TIME_NS = 90; // Address and chip-enable access time.
    localparam int RESET_PULSE_NS = 500; // Minimum reset low pulse.
    localparam int RESET_READY_NS = 20000; // Recovery time during embedded operation.
    localparam int RESET_HIGH_TO_READ_NS = 50; // Reset high to first read.
    localparam int WRITE_PULSE_NS = 45; // Write strobe low time.
    // Least times round up to whole cycles, at least one.
    localparam int ACC_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_CYC = (RESET_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RH_CYC = (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 9; // Width of the shared delay counter.

    // ****************************************************************
    // Command interface values.
    // ****************************************************************
    localparam logic [17:0] UNLOCK1_ADDR = 18'h00555; // First unlock address.
    localparam logic [17:0] UNLOCK2_ADDR = 18'h002AA; // Second unlock address.
    localparam logic [15:0] UNLOCK1_DATA = 16'h00AA; // First unlock data.
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055; // Second unlock data.
    localparam logic [15:0] AUTOSEL_CMD = 16'h0090; // Autoselect command.
    localparam logic [15:0] RESET_CMD = 16'h00F0; // Reset command.
    localparam logic [1:0] AS_MANUF = 2'h0; // Manufacturer code offset.
    localparam logic [1:0] AS_DEVICE = 2'h1; // Device code offset.
    localparam logic [1:0] AS_PROTECT = 2'h2; // Protection status offset.
    localparam logic [1:0] AS_CONT = 2'h3; // Continuation code offset.
    localparam logic [7:0] PROT_YES = 8'h01; // Protected sector answer.
    localparam logic [7:0] PROT_NO = 8'h00; // Unprotected sector answer.

    // ****************************************************************
    // Sector numbering.
    // ****************************************************************
    localparam int SECTORS = 11; // Sectors per layout.
    localparam logic [3:0] SECT_BAD = 4'hF; // Unused sector code.

    // Controller states.
    typedef enum logic [2:0] {
        FBMAC_IDLE, FBMAC_RST_LOW, FBMAC_RST_WAIT, FBMAC_READ, FBMAC_WRITE, FBMAC_GAP
    } fbmac_state_t;

endpackage : fbmac_pkg
